// ### core/display_page_cmds.sv
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "display_page_regs.svh"

// Functional notes
// - Command 10h sets picture start page bits
// - Picture field n means page n+1
// - Command 11h: bit7 enable, bits3-0 page
// - Movie enable zero disables, reset clears
// - Movie field n means page n+1
// - Command 12h sets length minus one
// - Gray mode allows lengths one or two
// - Undefined values leave setting unchanged
// - Command 31h bit7 selects binary mode
// - Command 30h bit0 selects movie display
module display_page_cmds (
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic [7:0]                  addr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic [7:0]                       rdata_o,
  output display_page_pkg::display_cfg_s   cfg_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic field_ok(input logic [3:0] field, input logic binary);
    field_ok = binary || (field <= `GRAY_MAX_FIELD);
  endfunction

  function automatic logic [4:0] page_of(input logic [3:0] field);
    page_of = {1'b0, field} + `PAGE_BASE;
  endfunction

  function automatic logic [3:0] field_of(input logic [4:0] page);
    logic [4:0] diff;
    diff     = page - `PAGE_BASE;
    field_of = diff[3:0];
  endfunction

  // ----------------------------------------
  // Byte framing
  // ----------------------------------------
  logic                            pair_valid;
  display_page_pkg::cmd_pair_s     pair;
  display_page_pkg::frame_state_e  frame_state;
  display_page_pkg::display_cfg_s  cfg_reg;
  logic [3:0]                      pfield;
  logic                            pfield_ok;

  cmd_byte_framer u_framer (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .byte_valid_i (wr_i && addr_i == `CMD_PORT_ADDR),
    .byte_i       (wdata_i),
    .pair_valid_o (pair_valid),
    .pair_o       (pair),
    .state_o      (frame_state)
  );

  assign cfg_o     = cfg_reg;
  assign pfield    = pair.param[`PAGE_FIELD_MSB:0];
  // Judged against the mode in force when the pair completes
  assign pfield_ok = field_ok(pfield, cfg_reg.binary_gray_select);

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  // Picture start, low nibble only
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg.picture_first_page <= `PIC_PAGE_RST;
    end else if (pair_valid && pair.cmd == `CMD_PICTURE_START && pfield_ok) begin
      cfg_reg.picture_first_page <= page_of(pfield);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg.movie_first_page  <= `MOVIE_PAGE_RST;
      cfg_reg.movie_play_enable <= `MOVIE_EN_RST;
    end else if (pair_valid && pair.cmd == `CMD_MOVIE_START && pfield_ok) begin
      cfg_reg.movie_first_page  <= page_of(pfield);
      cfg_reg.movie_play_enable <= pair.param[`MOVIE_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg.movie_page_count <= `MOVIE_COUNT_RST;
    end else if (pair_valid && pair.cmd == `CMD_MOVIE_LENGTH && pfield_ok) begin
      cfg_reg.movie_page_count <= page_of(pfield);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg.binary_gray_select <= `BINARY_GRAY_RST;
    end else if (pair_valid && pair.cmd == `CMD_BINARY_GRAY) begin
      cfg_reg.binary_gray_select <= pair.param[`BINARY_GRAY_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_reg.picture_movie_select <= `PICTURE_MOVIE_RST;
    end else if (pair_valid && pair.cmd == `CMD_DISPLAY_MODE) begin
      cfg_reg.picture_movie_select <= pair.param[`PICTURE_MOVIE_BIT];
    end
  end

  // ----------------------------------------
  // Readback, valid one cycle after rd_i
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `RDATA_IDLE;
    end else if (rd_i) begin
      unique case (addr_i)
        `FRAMER_STATE_ADDR: rdata_o <= {7'h00, frame_state};
        `CMD_PICTURE_START: rdata_o <= {4'h0, field_of(cfg_reg.picture_first_page)};
        `CMD_MOVIE_START:   rdata_o <= {cfg_reg.movie_play_enable, 3'h0,
                                        field_of(cfg_reg.movie_first_page)};
        `CMD_MOVIE_LENGTH:  rdata_o <= {4'h0, field_of(cfg_reg.movie_page_count)};
        `CMD_DISPLAY_MODE:  rdata_o <= {7'h00, cfg_reg.picture_movie_select};
        `CMD_BINARY_GRAY:   rdata_o <= {cfg_reg.binary_gray_select, 7'h00};
        default:            rdata_o <= `RDATA_IDLE;
      endcase
    end else begin
      rdata_o <= `RDATA_IDLE;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_pair(logic [7:0] code);
    pair_valid && pair.cmd == code;
  endsequence

  AST_PIC_UPDATE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_PICTURE_START) ##0 pfield_ok
      |=> cfg_o.picture_first_page == {1'b0, $past(pfield)} + 5'h01)
    else $error("picture start page not taken");

  AST_PIC_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_PICTURE_START) ##0 !pfield_ok |=> $stable(cfg_o.picture_first_page))
    else $error("undefined picture page acted on");

  AST_MOVIE_EN: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_MOVIE_START) ##0 pfield_ok
      |=> cfg_o.movie_play_enable == $past(pair.param[7])
          && cfg_o.movie_first_page == {1'b0, $past(pfield)} + 5'h01)
    else $error("movie start not taken");

  AST_MOVIE_HOLD: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_MOVIE_START) ##0 !pfield_ok
      |=> $stable(cfg_o.movie_first_page) && $stable(cfg_o.movie_play_enable))
    else $error("undefined movie start acted on");

  AST_LEN_GRAY: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_MOVIE_LENGTH) ##0 !cfg_o.binary_gray_select ##0 pfield > 4'h1
      |=> $stable(cfg_o.movie_page_count))
    else $error("gray length above two pages accepted");

  AST_LEN_UPDATE: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_MOVIE_LENGTH) ##0 cfg_o.binary_gray_select
      |=> cfg_o.movie_page_count == {1'b0, $past(pfield)} + 5'h01)
    else $error("movie length not taken");

  AST_MODE_SEL: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_BINARY_GRAY) |=> cfg_o.binary_gray_select == $past(pair.param[7]))
    else $error("binary or gray select wrong");

  AST_DISP_SEL: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_pair(`CMD_DISPLAY_MODE) |=> cfg_o.picture_movie_select == $past(pair.param[0]))
    else $error("display mode select wrong");

  AST_WRITE_LATENCY: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    // A pair completing in the same cycle updates legally on the next edge
    (wr_i && addr_i == `CMD_PORT_ADDR && frame_state == display_page_pkg::FRAME_CMD
      && !pair_valid) |=> $stable(cfg_o))
    else $error("setting changed before parameter byte");

  AST_RD_PIC: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (rd_i && addr_i == `CMD_PICTURE_START)
      |=> rdata_o == {4'h0, $past(cfg_o.picture_first_page[3:0]) - 4'h1})
    else $error("picture readback wrong");

  sequence s_gray_len;
    s_pair(`CMD_MOVIE_LENGTH) ##0 !cfg_o.binary_gray_select;
  endsequence

  AST_LEN_GRAY_OK: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_gray_len ##0 (pfield <= `GRAY_MAX_FIELD)
      |=> cfg_o.movie_page_count == {1'b0, $past(pfield)} + `PAGE_BASE)
    else $error("gray movie length not taken");

  // Unknown codes swallow their parameter and touch nothing
  AST_UNKNOWN_CMD: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (pair_valid && !(pair.cmd inside {`CMD_PICTURE_START, `CMD_MOVIE_START,
                                      `CMD_MOVIE_LENGTH, `CMD_DISPLAY_MODE,
                                      `CMD_BINARY_GRAY})) |=> $stable(cfg_o))
    else $error("unknown command changed a setting");

  AST_RD_FRAMER: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (rd_i && addr_i == `FRAMER_STATE_ADDR) |=> rdata_o == {7'h00, $past(frame_state)})
    else $error("framer state readback wrong");

endmodule

// ### core/display_page_regs.svh
`ifndef DISPLAY_PAGE_REGS_SVH
`define DISPLAY_PAGE_REGS_SVH

// ----------------------------------------
// Register port addresses
// ----------------------------------------
`define CMD_PORT_ADDR       8'h00
`define FRAMER_STATE_ADDR   8'h01

// ----------------------------------------
// Command codes, also used as readback addresses
// ----------------------------------------
`define CMD_PICTURE_START   8'h10
`define CMD_MOVIE_START     8'h11
`define CMD_MOVIE_LENGTH    8'h12
`define CMD_DISPLAY_MODE    8'h30
`define CMD_BINARY_GRAY     8'h31

// ----------------------------------------
// Parameter field positions
// ----------------------------------------
`define PAGE_FIELD_MSB      3
`define MOVIE_EN_BIT        7
`define BINARY_GRAY_BIT     7
`define PICTURE_MOVIE_BIT   0

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PIC_PAGE_RST        5'h01
`define MOVIE_PAGE_RST      5'h01
`define MOVIE_EN_RST        1'b0
`define MOVIE_COUNT_RST     5'h02
`define BINARY_GRAY_RST     1'b0
`define PICTURE_MOVIE_RST   1'b0
`define GRAY_MAX_FIELD      4'h1
`define PAGE_BASE           5'h01
`define RDATA_IDLE          8'h00

`endif

// ### core/display_page_pkg.sv
package display_page_pkg;

  typedef enum logic [0:0] {
    FRAME_CMD   = 1'b0,
    FRAME_PARAM = 1'b1
  } frame_state_e;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] param;
  } cmd_pair_s;

  // Page numbers are 1-based, 1 to 16
  typedef struct packed {
    logic [4:0] picture_first_page;
    logic [4:0] movie_first_page;
    logic       movie_play_enable;
    logic [4:0] movie_page_count;
    logic       binary_gray_select;
    logic       picture_movie_select;
  } display_cfg_s;

endpackage

// ### core/cmd_byte_framer.sv
`timescale 1ns/10ps
`include "display_page_regs.svh"

module cmd_byte_framer (
  input  wire logic                        mclk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        byte_valid_i,
  input  wire logic [7:0]                  byte_i,
  output logic                             pair_valid_o,
  output display_page_pkg::cmd_pair_s      pair_o,
  output display_page_pkg::frame_state_e   state_o
);

  display_page_pkg::frame_state_e state_reg;
  logic [7:0]                     cmd_reg;

  assign state_o = state_reg;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= display_page_pkg::FRAME_CMD;
    end else if (byte_valid_i) begin
      unique case (state_reg)
        display_page_pkg::FRAME_CMD:   state_reg <= display_page_pkg::FRAME_PARAM;
        display_page_pkg::FRAME_PARAM: state_reg <= display_page_pkg::FRAME_CMD;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_reg <= `RDATA_IDLE;
    end else if (byte_valid_i && state_reg == display_page_pkg::FRAME_CMD) begin
      cmd_reg <= byte_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_valid_o <= 1'b0;
      pair_o       <= '0;
    end else begin
      pair_valid_o <= byte_valid_i && state_reg == display_page_pkg::FRAME_PARAM;
      if (byte_valid_i && state_reg == display_page_pkg::FRAME_PARAM) begin
        pair_o.cmd   <= cmd_reg;
        pair_o.param <= byte_i;
      end
    end
  end

  sequence s_cmd_then_param;
    (byte_valid_i && state_reg == display_page_pkg::FRAME_CMD) ##1 byte_valid_i;
  endsequence

  AST_PAIR_FORMED: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    s_cmd_then_param |=> pair_valid_o && pair_o.cmd == $past(byte_i, 2)
                          && pair_o.param == $past(byte_i))
    else $error("command and parameter not paired");

  AST_NO_EARLY_PAIR: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (byte_valid_i && state_reg == display_page_pkg::FRAME_CMD) |=> !pair_valid_o)
    else $error("pair emitted on command byte");

endmodule

// ### test/host_model.sv
`timescale 1ns/10ps

module host_model (
  input  wire logic       mclk_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // Changed just after an edge, held until the edge that takes it
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    wr_o    <= w;
    rd_o    <= r;
    addr_o  <= a;
    wdata_o <= d;
    @(posedge mclk_i);
  endtask

  task automatic send(input logic [7:0] cmd, input logic [7:0] prm);
    bus(1'b1, 1'b0, 8'h00, cmd);
    bus(1'b1, 1'b0, 8'h00, prm);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
endmodule

// ### test/display_page_cmds_bench.sv
`timescale 1ns/10ps

module display_page_cmds_bench;
  logic                          mclk_i;
  logic                          rstn_i;
  logic                    [7:0] addr_i;
  logic                    [7:0] wdata_i;
  logic                          wr_i;
  logic                          rd_i;
  logic                    [7:0] rdata_o;
  display_page_pkg::display_cfg_s cfg_o;
  display_page_pkg::display_cfg_s exp;
  int                            num_errors = 0;
  int                            n_tests    = 0;

  host_model u_host_model (
    .mclk_i  (mclk_i),
    .addr_o  (addr_i),
    .wdata_o (wdata_i),
    .wr_o    (wr_i),
    .rd_o    (rd_i)
  );

  display_page_cmds u_display_page_cmds (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .wr_i    (wr_i),
    .rd_i    (rd_i),
    .rdata_o (rdata_o),
    .cfg_o   (cfg_o)
  );

  initial mclk_i = 1'b0;
  always #12.5 mclk_i = ~mclk_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [17:0] seen, input logic [17:0] expv);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Pair lands one cycle after the parameter write, the setting one cycle later
  task automatic apply(input logic [7:0] c, input logic [7:0] p);
    u_host_model.send(c, p);
    @(posedge mclk_i);
    #1;
    check(cfg_o, exp);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_host_model.bus(1'b0, 1'b1, a, 8'h00);
    #1;
    check({10'h000, rdata_o}, {10'h000, e});
    u_host_model.bus(1'b0, 1'b0, 8'h00, 8'h00);
    // Read data stand one cycle only
    #1;
    check({10'h000, rdata_o}, 18'h00000);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    exp = '{5'h01, 5'h01, 1'b0, 5'h02, 1'b0, 1'b0};
    check(cfg_o, exp);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h12, 8'h01);
  endtask

  // Gray mode: fields above 1 must be dropped whole
  task automatic t_gray;
    exp.picture_first_page = 5'h02;
    apply(8'h10, 8'hf1);
    apply(8'h10, 8'h02);
    exp.movie_first_page  = 5'h02;
    exp.movie_play_enable = 1'b1;
    apply(8'h11, 8'h81);
    apply(8'h11, 8'h03);
    exp.movie_page_count = 5'h01;
    apply(8'h12, 8'h00);
    apply(8'h12, 8'h02);
    rd_chk(8'h12, 8'h00);
    exp.movie_play_enable = 1'b0;
    apply(8'h11, 8'h01);
  endtask

  task automatic t_binary;
    exp.binary_gray_select = 1'b1;
    apply(8'h31, 8'h80);
    rd_chk(8'h31, 8'h80);
    for (int n = 0; n < 16; n++) begin
      exp.picture_first_page = 5'(n + 1);
      apply(8'h10, {4'ha, 4'(n)});
    end
    exp.movie_first_page  = 5'h10;
    exp.movie_play_enable = 1'b1;
    apply(8'h11, 8'hff);
    rd_chk(8'h11, 8'h8f);
    exp.movie_page_count = 5'h10;
    apply(8'h12, 8'hff);
    exp.picture_movie_select = 1'b1;
    apply(8'h30, 8'h01);
    rd_chk(8'h30, 8'h01);
    exp.binary_gray_select = 1'b0;
    apply(8'h31, 8'h00);
  endtask

  // Lone command must not touch anything until its parameter
  task automatic t_framing;
    u_host_model.bus(1'b1, 1'b0, 8'h00, 8'h12);
    u_host_model.bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1;
    check(cfg_o, exp);
    rd_chk(8'h01, 8'h01);
    exp.movie_page_count = 5'h02;
    u_host_model.bus(1'b1, 1'b0, 8'h00, 8'h01);
    u_host_model.bus(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge mclk_i);
    #1;
    check(cfg_o, exp);
    rd_chk(8'h01, 8'h00);
    u_host_model.bus(1'b1, 1'b0, 8'h10, 8'h05);
    u_host_model.bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1;
    check(cfg_o, exp);
    rd_chk(8'h40, 8'h00);
    apply(8'h40, 8'hff);
    // Two pairs back to back, no idle cycle between them
    exp.picture_first_page = 5'h01;
    exp.movie_page_count   = 5'h01;
    u_host_model.bus(1'b1, 1'b0, 8'h00, 8'h10);
    u_host_model.bus(1'b1, 1'b0, 8'h00, 8'h00);
    apply(8'h12, 8'h00);
  endtask

  initial begin
    rstn_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    t_reset();
    t_gray();
    t_binary();
    t_framing();
    summarize();
  end

  // Whole run needs well under 500 cycles
  initial begin
    #(25 * 3000);
    num_errors++;
    summarize();
  end
endmodule
